// ==== mpsc_regs.sv ====
`timescale 1ns/1ns
module mpsc_regs
   import mpsc_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // register access port (from serial interface)
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   // measurement engine status
   input  wire logic        resistance_meas_status,
   input  wire logic        inductance_meas_status,
   input  wire logic        backemf_meas_status,
   input  wire logic        mechanical_meas_status,
   input  wire logic [3:0]  backemf_meas_pwm_code,
   // start-up control
   input  wire logic        force_align_en,
   input  wire logic [1:0]  startup_method,
   input  wire logic        align_done,
   output logic             hold_in_align,
   // command outputs
   output logic             nv_store_cmd,
   output logic             nv_load_cmd,
   output logic             fault_clear_cmd,
   output logic             retry_count_clear_cmd,
   output logic             watchdog_tickle,
   output logic [8:0]       align_angle
);
   // ------------------------------------------------------------
   // status capture
   // ------------------------------------------------------------
   logic [31:0] meas_status;       // registered status word
   logic [31:0] next_meas_status;

   always_comb begin
      next_meas_status = MPSC_RESET_VALUE;  // reserved bits stay zero
      next_meas_status[MPSC_RES_BIT]  = resistance_meas_status;
      next_meas_status[MPSC_IND_BIT]  = inductance_meas_status;
      next_meas_status[MPSC_BEMF_BIT] = backemf_meas_status;
      next_meas_status[MPSC_MECH_BIT] = mechanical_meas_status;
      next_meas_status[MPSC_PWM_MSB:MPSC_PWM_LSB] = backemf_meas_pwm_code;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meas_status <= MPSC_RESET_VALUE;
      end else begin
         meas_status <= next_meas_status;
      end
   end

   // ------------------------------------------------------------
   // write decode and command decoder
   // ------------------------------------------------------------
   mpsc_cmd_if cmd ();
   assign cmd.wr_ctrl = reg_wr && (reg_addr == MPSC_CMD_CTRL_OFS);
   assign cmd.wdata   = reg_wdata;  // reserved bits are never looked at

   logic tick_raw;  // one-cycle tickle from decoder

   mpsc_cmd_dec u_dec (
      .clock                 (clock),
      .resetn                (resetn),
      .cmd                   (cmd),
      .nv_store_cmd          (nv_store_cmd),
      .nv_load_cmd           (nv_load_cmd),
      .fault_clear_cmd       (fault_clear_cmd),
      .retry_count_clear_cmd (retry_count_clear_cmd),
      .tickle_pulse          (tick_raw),
      .align_angle           (align_angle)
   );
   // decoder already self-clears the tickle after one cycle
   assign watchdog_tickle = tick_raw;

   // ------------------------------------------------------------
   // read mux and alignment hold
   // ------------------------------------------------------------
   logic [31:0] next_rdata;
   logic        next_hold;

   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            MPSC_MEAS_STATUS_OFS: next_rdata = meas_status;
            // write-only fields read zero; tickle shows while pending
            MPSC_CMD_CTRL_OFS: begin
               next_rdata = MPSC_RESET_VALUE;
               next_rdata[MPSC_TICKLE_BIT] = cmd.tickle_seen;
            end
            default: next_rdata = MPSC_RESET_VALUE;  // unmapped reads zero
         endcase
      end
      // hold only for alignment methods; other methods ignore the force bit
      next_hold = force_align_en && align_done &&
                  ((startup_method == 2'(MPSC_SU_ALIGN)) ||
                   (startup_method == 2'(MPSC_SU_DOUBLE_ALIGN)));
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata     <= MPSC_RESET_VALUE;
         hold_in_align <= 1'b0;
      end else begin
         reg_rdata     <= next_rdata;
         hold_in_align <= next_hold;
      end
   end
endmodule : mpsc_regs

// ==== mpsc_pkg.sv ====
package mpsc_pkg;
   // ------------------------------------------------------------
   // register offsets (printed offsets, word registers)
   // ------------------------------------------------------------
   localparam logic [7:0]  MPSC_MEAS_STATUS_OFS = 8'hE8;  // measurement_status
   localparam logic [7:0]  MPSC_CMD_CTRL_OFS    = 8'hEA;  // device_command_control
   localparam logic [31:0] MPSC_RESET_VALUE     = 32'h00000000;
   // ------------------------------------------------------------
   // measurement_status fields
   // ------------------------------------------------------------
   localparam int MPSC_RES_BIT   = 31;
   localparam int MPSC_IND_BIT   = 30;
   localparam int MPSC_BEMF_BIT  = 29;
   localparam int MPSC_MECH_BIT  = 28;
   localparam int MPSC_PWM_MSB   = 27;
   localparam int MPSC_PWM_LSB   = 24;
   // ------------------------------------------------------------
   // device_command_control fields
   // ------------------------------------------------------------
   localparam int MPSC_NV_STORE_BIT  = 31;
   localparam int MPSC_NV_LOAD_BIT   = 30;
   localparam int MPSC_FLT_CLR_BIT   = 29;
   localparam int MPSC_RETRY_CLR_BIT = 28;
   localparam int MPSC_ANGLE_MSB     = 19;
   localparam int MPSC_ANGLE_LSB     = 11;
   localparam int MPSC_TICKLE_BIT    = 10;
   localparam logic [9:0] MPSC_ANGLE_WRAP = 10'h168;  // 360 degrees
   // ------------------------------------------------------------
   // start-up sequencing
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MPSC_SU_IPD, MPSC_SU_SLOW_CYCLE, MPSC_SU_ALIGN, MPSC_SU_DOUBLE_ALIGN
   } mpsc_startup_t;
endpackage : mpsc_pkg

// ==== mpsc_cmd_if.sv ====
`timescale 1ns/1ns
// command pulses from the register file to the command decoder, tickle status back
interface mpsc_cmd_if;
   logic       wr_ctrl;     // one-cycle write strobe to control register
   logic [31:0] wdata;      // write data
   logic       tickle_seen; // tickle bit currently held
   modport regs (output wr_ctrl, output wdata, input tickle_seen);
   modport dec  (input wr_ctrl, input wdata, output tickle_seen);
endinterface : mpsc_cmd_if

// ==== mpsc_cmd_dec.sv ====
`timescale 1ns/1ns
module mpsc_cmd_dec
   import mpsc_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // register side
   mpsc_cmd_if.dec         cmd,
   // decoded outputs
   output logic            nv_store_cmd,
   output logic            nv_load_cmd,
   output logic            fault_clear_cmd,
   output logic            retry_count_clear_cmd,
   output logic            tickle_pulse,
   output logic [8:0]      align_angle
);
   // ------------------------------------------------------------
   // next-state computation
   // ------------------------------------------------------------
   logic       next_store, next_load, next_fclr, next_rclr, next_tick;
   logic [8:0] next_angle;
   logic [9:0] wr_angle;  // raw field widened for the wrap compare

   always_comb begin
      wr_angle   = {1'b0, cmd.wdata[MPSC_ANGLE_MSB:MPSC_ANGLE_LSB]};
      next_store = 1'b0;
      next_load  = 1'b0;
      next_fclr  = 1'b0;
      next_rclr  = 1'b0;
      next_tick  = 1'b0;
      next_angle = align_angle;
      if (cmd.wr_ctrl) begin
         // commands are one-shot pulses; only the angle is kept
         next_store = cmd.wdata[MPSC_NV_STORE_BIT];
         next_load  = cmd.wdata[MPSC_NV_LOAD_BIT];
         next_fclr  = cmd.wdata[MPSC_FLT_CLR_BIT];
         next_rclr  = cmd.wdata[MPSC_RETRY_CLR_BIT];
         next_tick  = cmd.wdata[MPSC_TICKLE_BIT];
         // angle reduced modulo 360; one subtract is enough for 9 bits
         if (wr_angle >= MPSC_ANGLE_WRAP) begin
            next_angle = 9'(wr_angle - MPSC_ANGLE_WRAP);
         end else begin
            next_angle = wr_angle[8:0];
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nv_store_cmd          <= 1'b0;
         nv_load_cmd           <= 1'b0;
         fault_clear_cmd       <= 1'b0;
         retry_count_clear_cmd <= 1'b0;
         tickle_pulse          <= 1'b0;
         align_angle           <= 9'h000;
      end else begin
         nv_store_cmd          <= next_store;
         nv_load_cmd           <= next_load;
         fault_clear_cmd       <= next_fclr;
         retry_count_clear_cmd <= next_rclr;
         tickle_pulse          <= next_tick;
         align_angle           <= next_angle;
      end
   end

   // tickle bit reads back one for exactly the cycle it is held
   assign cmd.tickle_seen = tickle_pulse;
endmodule : mpsc_cmd_dec

// ==== mpsc_regs_checker.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// checker on the register bank ports
// ----------------------------------------
module mpsc_regs_checker
   import mpsc_pkg::*;
(
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        resistance_meas_status,
   input wire logic        inductance_meas_status,
   input wire logic        backemf_meas_status,
   input wire logic        mechanical_meas_status,
   input wire logic [3:0]  backemf_meas_pwm_code,
   input wire logic        force_align_en,
   input wire logic [1:0]  startup_method,
   input wire logic        align_done,
   input wire logic        hold_in_align,
   input wire logic        nv_store_cmd,
   input wire logic        nv_load_cmd,
   input wire logic        fault_clear_cmd,
   input wire logic        retry_count_clear_cmd,
   input wire logic        watchdog_tickle,
   input wire logic [8:0]  align_angle
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic        wr_ea;   // control write taken at this edge
   logic [8:0]  amod;    // written angle folded below 360
   logic [31:0] st_word; // status word the inputs imply
   assign wr_ea   = reg_wr && (reg_addr == MPSC_CMD_CTRL_OFS);
   assign amod    = (reg_wdata[19:11] >= 9'h168) ? reg_wdata[19:11] - 9'h168 : reg_wdata[19:11];
   assign st_word = {resistance_meas_status, inductance_meas_status, backemf_meas_status,
                     mechanical_meas_status, backemf_meas_pwm_code, 24'h000000};
   property p_store; wr_ea && reg_wdata[31] |=> nv_store_cmd; endproperty
   a_store: assert property (p_store) else $error("store pulse missing");
   property p_load; wr_ea && reg_wdata[30] |=> nv_load_cmd; endproperty
   a_load: assert property (p_load) else $error("load pulse missing");
   property p_fclr; fault_clear_cmd |-> $past(wr_ea) && $past(reg_wdata[29]); endproperty
   a_fclr: assert property (p_fclr) else $error("fault clear without write");
   property p_rclr; wr_ea && reg_wdata[28] |=> retry_count_clear_cmd; endproperty
   a_rclr: assert property (p_rclr) else $error("retry clear missing");
   property p_angle; wr_ea |=> align_angle == $past(amod); endproperty
   a_angle: assert property (p_angle) else $error("angle not folded");
   property p_tick; watchdog_tickle && !wr_ea |=> !watchdog_tickle; endproperty
   a_tick: assert property (p_tick) else $error("tickle not cleared");
   // a tickle write must show on the pin, or the clear check above proves nothing
   property p_tkset; wr_ea && reg_wdata[10] |=> watchdog_tickle; endproperty
   a_tkset: assert property (p_tkset) else $error("tickle not raised");
   // status word lags its inputs one cycle, read data one more
   property p_stat;
      reg_rd && reg_addr == MPSC_MEAS_STATUS_OFS |=> reg_rdata == $past(st_word, 2);
   endproperty
   a_stat: assert property (p_stat) else $error("status read wrong");
   property p_ctrd;
      reg_rd && reg_addr == MPSC_CMD_CTRL_OFS |=>
         reg_rdata == {21'h0, $past(watchdog_tickle), 10'h0};
   endproperty
   a_ctrd: assert property (p_ctrd) else $error("control read wrong");
   property p_hold;
      1'b1 |=> hold_in_align ==
         ($past(force_align_en) && $past(align_done) && $past(startup_method[1]));
   endproperty
   a_hold: assert property (p_hold) else $error("align hold wrong");
endmodule : mpsc_regs_checker

// ==== mpsc_host_model.sv ====
`timescale 1ns/1ns
// host model: drives the register port as the serial front end would
module mpsc_host_model
   import mpsc_pkg::*;
(
   input  wire logic [31:0] reg_rdata,
   input  wire logic        clock,
   output logic [7:0]       reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [31:0]      reg_wdata
);
   initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 42'h0;
   // data shows the inverse after the strobe, so stale data cannot pass
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clock);
      {reg_wdata, reg_wr} <= {~d, 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : rd
   task automatic tickle();
      wr(MPSC_CMD_CTRL_OFS, 32'h00000400);
   endtask : tickle
   // tickle, then read the control word while the tickle still stands
   task automatic tickle_rd(output logic [31:0] d);
      @(posedge clock);
      {reg_addr, reg_wdata, reg_wr} <= {MPSC_CMD_CTRL_OFS, 32'h00000400, 1'b1};
      @(posedge clock);
      {reg_wr, reg_rd} <= {1'b0, 1'b1};
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask : tickle_rd
endmodule : mpsc_host_model

// ==== motor_param_status_ctrl_regs_tb_top.sv ====
`timescale 1ns/1ns
module motor_param_status_ctrl_regs_tb_top
   import mpsc_pkg::*;
;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr;
   logic reg_wr, reg_rd, resistance_meas_status, inductance_meas_status, backemf_meas_status;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic mechanical_meas_status, force_align_en, align_done, hold_in_align, watchdog_tickle;
   logic [3:0] backemf_meas_pwm_code;
   logic [1:0] startup_method;
   logic nv_store_cmd, nv_load_cmd, fault_clear_cmd, retry_count_clear_cmd;
   logic [8:0] align_angle;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   mpsc_regs DUT (.*);
   mpsc_host_model u_host (.*);
   always #5 clock = ~clock;
   // ceiling far above the roughly eighty cycles the sequence needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // control write, then pulses and angle, then pulses gone a cycle later
   task automatic ctl(input logic [31:0] d, input logic [12:0] e);
      u_host.wr(MPSC_CMD_CTRL_OFS, d);
      @(negedge clock);
      chk({19'h0, nv_store_cmd, nv_load_cmd, fault_clear_cmd, retry_count_clear_cmd,
           align_angle}, {19'h0, e});
      @(negedge clock);
      chk({28'h0, nv_store_cmd, nv_load_cmd, fault_clear_cmd, retry_count_clear_cmd},
          32'h0);
   endtask : ctl
   task automatic set_st(input logic [7:0] v);
      @(posedge clock);
      {resistance_meas_status, inductance_meas_status, backemf_meas_status,
       mechanical_meas_status, backemf_meas_pwm_code} <= v;
   endtask : set_st
   initial begin
      {resistance_meas_status, inductance_meas_status, backemf_meas_status,
       mechanical_meas_status, backemf_meas_pwm_code} = 8'h00;
      {force_align_en, align_done, startup_method} = 4'h0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      u_host.rd(MPSC_MEAS_STATUS_OFS, rv);
      chk(rv, MPSC_RESET_VALUE);
      u_host.rd(MPSC_CMD_CTRL_OFS, rv);
      chk(rv, MPSC_RESET_VALUE);
      set_st(8'hAA);
      u_host.rd(MPSC_MEAS_STATUS_OFS, rv);
      chk(rv, 32'hAA000000);
      set_st(8'h55);
      u_host.wr(MPSC_MEAS_STATUS_OFS, 32'hFFFFFFFF);
      u_host.rd(MPSC_MEAS_STATUS_OFS, rv);
      chk(rv, 32'h55000000);
      u_host.rd(8'h00, rv);
      chk(rv, 32'h0);
      $display("status tests done");
      ctl(32'h800C8000, {4'h8, 9'h028});
      ctl(32'h400B3800, {4'h4, 9'h167});
      ctl(32'h200B4000, {4'h2, 9'h000});
      ctl(32'h100FF800, {4'h1, 9'h097});
      ctl(32'h0FF003FF, {4'h0, 9'h000});
      u_host.tickle();
      @(negedge clock);
      chk({31'h0, watchdog_tickle}, 32'h1);
      @(negedge clock);
      chk({31'h0, watchdog_tickle}, 32'h0);
      u_host.tickle_rd(rv);
      chk(rv, 32'h00000400);
      $display("command tests done");
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         {force_align_en, align_done, startup_method} <= {i[2], i[3], i[1:0]};
         repeat (2) @(negedge clock);
         chk({31'h0, hold_in_align}, {31'h0, i[3] & i[2] & i[1]});
      end
      $display("alignment tests done");
      report_and_stop();
   end
endmodule : motor_param_status_ctrl_regs_tb_top
bind mpsc_regs mpsc_regs_checker u_chk (.*);
